// [lat_pkg.sv]
package lat_pkg;

    // bit times and clock rates
    localparam int BIT100_NS      = 10;
    localparam int BIT10_NS       = 100;
    localparam int MCLK_NS        = 50;

    // latencies in bit times (10BASE-T start delay kept in half bits)
    localparam int TX_SSD_BITS    = 5;
    localparam int TX_ESD_BITS    = 5;
    localparam int CRS_ON_TX_BITS = 20;
    localparam int CRS_ON_FX_BITS = 10;
    localparam int RXD_TX_BITS    = 24;
    localparam int RXD_FX_BITS    = 14;
    localparam int CRS_OFF_TX_BITS = 24;
    localparam int CRS_OFF_FX_BITS = 14;
    localparam int TX10_HALF_BITS = 7;
    localparam int RXDV10_BITS    = 10;
    localparam int RXD10_BITS     = 8;

    // 10BASE-T times in ns
    localparam int EOP_HIGH_MIN_NS = 250;
    localparam int EOP_HIGH_TYP_NS = 300;
    localparam int CRS10_TYP_NS    = 630;
    localparam int CRS10_MAX_NS    = 1000;

    // derived cycle counts at the link clock
    localparam int EOP_HIGH_CYC = (EOP_HIGH_TYP_NS + BIT10_NS - 1) / BIT10_NS;
    localparam int CRS10_CYC    = CRS10_TYP_NS / BIT10_NS;

    localparam int DLY_W = 6;

    typedef enum logic [1:0] {
        MODE_100TX,
        MODE_100FX,
        MODE_10MII,
        MODE_10SER
    } mode_t;

    // what the line side of the link presents each bit time
    typedef struct packed {
        logic tx_active;
        logic tx_data;
        logic tx_eop_high;
    } line_tx_t;

    typedef struct packed {
        logic crs;
        logic rx_dv;
        logic [3:0] rxd;
    } mii_rx_t;

endpackage

// [lat_delay.sv]
`timescale 1ns/1ps
// variable-length shift delay used for every latency path
module lat_delay #(
    parameter int W     = 1,
    parameter int DEPTH = 40
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic [5:0]              sel_i,
    input  wire logic [W-1:0]            d_i,
    output logic      [W-1:0]            q_o
);

    logic [W-1:0] pipe_r [DEPTH];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                pipe_r[i] <= '0;
            end
        end else begin
            pipe_r[0] <= d_i;
            for (int i = 1; i < DEPTH; i++) begin
                pipe_r[i] <= pipe_r[i-1];
            end
        end
    end

    // sel of zero passes straight; sel n gives n cycles of delay
    always_comb begin
        if (sel_i == 6'h00) begin
            q_o = d_i;
        end else begin
            q_o = pipe_r[int'(sel_i) - 1];
        end
    end

endmodule

// [phy_mii_datapath_latency.sv]
`timescale 1ns/1ps
// How it works
// - start code leaves 5 bits after tx_en
// - end code leaves 5 bits after tx_en drop
// - 100 Mb/s bit time is 10 ns
// - carrier on 20 bits TX, 10 FX
// - receive data out 24 TX, 14 FX
// - carrier off 24 bits TX, 14 FX
// - 10M mii samples on tx_clk fall
// - serial mode captures txd0 on rise
// - serial rxd0 and rx_dv change on fall
// - 10BASE-T line starts 3.5 bits later in mii, 4 in serial
// - 10 Mb/s bit time is 100 ns
// - line held high 300 ns after frame
// - 10M carrier within 1000 ns, typ 630
// - 10M rx_dv 10 bits after preamble
// - 10M receive data 8 bits late
// - rx_clk phases may stretch, never shorten
module phy_mii_datapath_latency
    import lat_pkg::*;
(
    input  wire logic                  mclk_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  bit_clk_i,
    input  wire lat_pkg::mode_t        mode_i,
    input  wire logic                  tx_en_i,
    input  wire logic [3:0]            txd_i,
    input  wire logic                  line_rx_act_i,
    input  wire logic                  line_rx_code_i,
    input  wire logic [3:0]            line_rxd_i,
    output lat_pkg::line_tx_t          line_tx_o,
    output lat_pkg::mii_rx_t           mii_rx_o,
    output logic                       tx_clk_o,
    output logic                       rx_clk_o,
    output logic                       link_crs_mclk_o
);
    import lat_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // bit_clk_i runs at one bit time; the link side lives here

    localparam int DLY_DEPTH = 40;

    typedef struct packed {
        logic [1:0] mode_a;       // mode_i passed through three flops
        logic [1:0] mode_b;
        logic [1:0] mode_c;
        logic [1:0] mode_q;
        logic       tx_en_rise;   // rising-edge sampled tx_en
        logic [3:0] txd_rise;
        logic       tx_en_fall;   // falling-edge copy moved into rise domain
        logic [3:0] txd_fall;
        logic       tx_prev;
        logic [3:0] eop_cnt;
        logic       eop_high;
        logic       div;
    } link_st_t;

    link_st_t st_r;
    link_st_t st_nxt;
    logic     tx_en_neg_r;
    logic [3:0] txd_neg_r;
    logic       tx_en_cap;
    logic [3:0] txd_cap;
    logic [5:0] tx_sel;
    logic [5:0] crs_sel;
    logic [5:0] dv_sel;
    logic [5:0] rxd_sel;
    logic       tx_en_dly;
    logic [3:0] txd_dly;
    logic       crs_dly;
    logic       dv_dly;
    logic [3:0] rxd_dly;
    logic       crs_off_dly;
    logic [2:0] crs_sync_r;

    function automatic logic [5:0] bits(input int n);
        return n[5:0];
    endfunction

    function automatic logic is_100(input logic [1:0] m);
        return (m == MODE_100TX) || (m == MODE_100FX);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // transmit capture edge

    // 10M mii samples on the falling edge of tx_clk; mac launched on rise
    always_ff @(negedge bit_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_en_neg_r <= 1'b0;
            txd_neg_r   <= 4'h0;
        end else begin
            tx_en_neg_r <= tx_en_i;
            txd_neg_r   <= txd_i;
        end
    end

    // serial and 100M capture on rise; serial uses txd bit 0 only
    always_comb begin
        if (st_r.mode_q == MODE_10MII) begin
            tx_en_cap = st_r.tx_en_fall;
            txd_cap   = st_r.txd_fall;
        end else if (st_r.mode_q == MODE_10SER) begin
            tx_en_cap = st_r.tx_en_rise;
            txd_cap   = {3'h0, st_r.txd_rise[0]};
        end else begin
            tx_en_cap = st_r.tx_en_rise;
            txd_cap   = st_r.txd_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-mode pipeline depths in bit clocks; receive ones in full, 100M transmit less the capture flop

    always_comb begin
        if (is_100(st_r.mode_q)) begin
            // one link clock stands for one 10 ns bit here
            // start and end share one path, both 5 bits
            tx_sel  = bits(TX_SSD_BITS - 1);
            if (st_r.mode_q == MODE_100TX) begin
                crs_sel = bits(CRS_ON_TX_BITS);
                dv_sel  = bits(RXD_TX_BITS);
                rxd_sel = bits(RXD_TX_BITS);
            end else begin
                crs_sel = bits(CRS_ON_FX_BITS);
                dv_sel  = bits(RXD_FX_BITS);
                rxd_sel = bits(RXD_FX_BITS);
            end
        end else begin
            // 100 ns bits mii capture on the fall already gives half a bit
            if (st_r.mode_q == MODE_10MII) begin
                tx_sel = bits(TX10_HALF_BITS / 2 - 1);
            end else begin
                tx_sel = bits(TX10_HALF_BITS / 2);
            end
            crs_sel = bits(CRS10_CYC);
            dv_sel  = bits(RXDV10_BITS);
            rxd_sel = bits(RXD10_BITS);
        end
    end

    lat_delay #(.W(5), .DEPTH(DLY_DEPTH)) u_tx_dly (
        .clk_i (bit_clk_i),
        .rst_i (sys_rst_i),
        .sel_i (tx_sel),
        .d_i   ({tx_en_cap, txd_cap}),
        .q_o   ({tx_en_dly, txd_dly})
    );

    lat_delay #(.W(1), .DEPTH(DLY_DEPTH)) u_crs_dly (
        .clk_i (bit_clk_i),
        .rst_i (sys_rst_i),
        .sel_i (crs_sel),
        .d_i   (line_rx_act_i),
        .q_o   (crs_dly)
    );

    // carrier drops on its own, longer path from the end code in 100M; 10M reuses the carrier-on depth
    lat_delay #(.W(1), .DEPTH(DLY_DEPTH)) u_off_dly (
        .clk_i (bit_clk_i),
        .rst_i (sys_rst_i),
        .sel_i ((st_r.mode_q == MODE_100TX) ? bits(CRS_OFF_TX_BITS) :
                (st_r.mode_q == MODE_100FX) ? bits(CRS_OFF_FX_BITS) : crs_sel),
        .d_i   (line_rx_act_i),
        .q_o   (crs_off_dly)
    );

    lat_delay #(.W(1), .DEPTH(DLY_DEPTH)) u_dv_dly (
        .clk_i (bit_clk_i),
        .rst_i (sys_rst_i),
        .sel_i (dv_sel),
        .d_i   (line_rx_code_i),
        .q_o   (dv_dly)
    );

    lat_delay #(.W(4), .DEPTH(DLY_DEPTH)) u_rxd_dly (
        .clk_i (bit_clk_i),
        .rst_i (sys_rst_i),
        .sel_i (rxd_sel),
        .d_i   (line_rxd_i),
        .q_o   (rxd_dly)
    );

    ////////////////////////////////////////////////////////////////////////////
    // link state

    always_comb begin
        st_nxt = st_r;
        st_nxt.mode_a     = mode_i;
        st_nxt.mode_b     = st_r.mode_a;
        st_nxt.mode_c     = st_r.mode_b;
        // mode pin counts only once the second and third flops agree
        if (st_r.mode_b == st_r.mode_c) begin
            st_nxt.mode_q = st_r.mode_c;
        end
        st_nxt.tx_en_rise = tx_en_i;
        st_nxt.txd_rise   = txd_i;
        st_nxt.tx_en_fall = tx_en_neg_r;
        st_nxt.txd_fall   = txd_neg_r;
        st_nxt.tx_prev    = tx_en_dly;
        st_nxt.div        = ~st_r.div;
        // end-of-frame idle high, 10M only, whatever the last bit
        if (!is_100(st_r.mode_q) && st_r.tx_prev && !tx_en_dly) begin
            st_nxt.eop_cnt  = 4'(EOP_HIGH_CYC);
            st_nxt.eop_high = 1'b1;
        end else if (st_r.eop_cnt > 4'h1) begin
            st_nxt.eop_cnt  = st_r.eop_cnt - 4'h1;
        end else begin
            st_nxt.eop_cnt  = 4'h0;
            st_nxt.eop_high = 1'b0;
        end
    end

    always_ff @(posedge bit_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs: line on rise, receive updates on fall in every mode

    always_ff @(posedge bit_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            line_tx_o <= '0;
            tx_clk_o  <= 1'b0;
        end else begin
            line_tx_o.tx_active   <= tx_en_dly;
            line_tx_o.tx_data     <= txd_dly[0];
            // taken from next state so the line goes high as data stops
            line_tx_o.tx_eop_high <= st_nxt.eop_high;
            tx_clk_o              <= st_r.div;
        end
    end

    // serial and mii receive both change at the falling edge
    always_ff @(negedge bit_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mii_rx_o <= '0;
            rx_clk_o <= 1'b0;
        end else begin
            mii_rx_o.crs   <= crs_dly | crs_off_dly;
            mii_rx_o.rx_dv <= dv_dly;
            mii_rx_o.rxd   <= (st_r.mode_q == MODE_10SER) ?
                              {3'h0, rxd_dly[0]} : rxd_dly;
            // one clock source only, so no phase is ever cut short
            rx_clk_o       <= ~st_r.div;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // carrier level into the system clock domain

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            crs_sync_r      <= 3'h0;
            link_crs_mclk_o <= 1'b0;
        end else begin
            crs_sync_r <= {crs_sync_r[1:0], mii_rx_o.crs};
            if (crs_sync_r[2] == crs_sync_r[1]) begin
                link_crs_mclk_o <= crs_sync_r[2];
            end
        end
    end

endmodule

// [lat_monitor.sv]
`timescale 1ns/1ps
module lat_monitor
    import lat_pkg::*;
(
    input  wire logic               sys_rst_i,
    input  wire logic               bit_clk_i,
    input  wire lat_pkg::mode_t     mode_i,
    input  wire logic               tx_en_i,
    input  wire logic               line_rx_act_i,
    input  wire logic               line_rx_code_i,
    input  wire lat_pkg::line_tx_t  line_tx_o,
    input  wire lat_pkg::mii_rx_t   mii_rx_o
);
    default clocking dc @(posedge bit_clk_i); endclocking
    default disable iff (sys_rst_i);
    mii_rx_t rise_q_r;
    // snapshot at the rise, so any change made there shows at the next fall
    always_ff @(posedge bit_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) rise_q_r <= '0;
        else rise_q_r <= mii_rx_o;
    end
    ////////////////////////////////////////////////////////////////////////
    a_tx_start_lat: assert property (
        !mode_i[1] && $rose(tx_en_i) |-> !line_tx_o.tx_active[*4] ##[1:3] line_tx_o.tx_active)
        else $error("tx start latency wrong");
    a_tx_end_lat: assert property (
        !mode_i[1] && $fell(tx_en_i) |-> line_tx_o.tx_active[*4] ##[1:3] !line_tx_o.tx_active)
        else $error("tx end latency wrong");
    a_crs_on_tx: assert property (
        mode_i == MODE_100TX && $rose(line_rx_act_i) |-> !mii_rx_o.crs[*8] ##[11:15] mii_rx_o.crs)
        else $error("carrier on latency wrong");
    a_rxdv_on_tx: assert property (
        mode_i == MODE_100TX && $rose(line_rx_code_i) |-> ##[22:26] mii_rx_o.rx_dv)
        else $error("receive data latency wrong");
    a_crs_off_tx: assert property (
        mode_i == MODE_100TX && $fell(line_rx_act_i) |-> mii_rx_o.crs[*8] ##[15:19] !mii_rx_o.crs)
        else $error("carrier off latency wrong");
    a_eop_high_hold: assert property (
        mode_i[1] && $fell(line_tx_o.tx_active) |-> ##1 line_tx_o.tx_eop_high[*2])
        else $error("end of frame high too short");
    a_crs10_bound: assert property (
        mode_i[1] && $rose(line_rx_act_i) |-> ##[1:10] mii_rx_o.crs)
        else $error("10M carrier too late");
    a_rxdv10_lat: assert property (
        mode_i[1] && $rose(line_rx_code_i) |-> ##[8:12] mii_rx_o.rx_dv)
        else $error("10M rx_dv latency wrong");
    a_rx_fall_only: assert property (
        @(negedge bit_clk_i) mii_rx_o == rise_q_r)
        else $error("receive outputs changed at the rise");
endmodule

// [mac_model.sv]
`timescale 1ns/1ps
module mac_model
    import lat_pkg::*;
(
    input  wire logic            bit_clk_i,
    input  wire lat_pkg::mode_t  mode_i,
    output logic                 tx_en_o,
    output logic [3:0]           txd_o
);
    initial begin
        tx_en_o = 1'b0;
        txd_o = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one nibble a bit clock; serial mode only looks at bit 0
    task automatic send(input int n);
        for (int i = 0; i <= n; i++) begin
            // 10M mii launches on the rise so the fall sample sees settled data
            if (mode_i == MODE_10MII) @(posedge bit_clk_i);
            else @(negedge bit_clk_i);
            tx_en_o <= (i < n);
            // released data shows the inverse, never a stale copy
            txd_o <= (i < n) ? 4'(i) : ~txd_o;
        end
    endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
    check_count++; \
    if ((got) !== (ex)) begin \
        mismatches++; \
        $display("Error %s expected %0d seen %0d", nm, ex, got); \
    end \
end
module tb_top;
    import lat_pkg::*;
    logic      mclk = 0, bit_clk = 0, rst = 1, rx_act = 0, rx_code = 0, tx_en, crs_m;
    logic [3:0] txd, rxd = 4'h5;
    mode_t     mode = MODE_100TX;
    line_tx_t  line_tx;
    mii_rx_t   mii_rx;
    int        mismatches = 0, check_count = 0, cyc = 0;
    always #25 mclk = ~mclk;
    always #16 bit_clk = ~bit_clk;
    phy_mii_datapath_latency uut (.mclk_i(mclk), .sys_rst_i(rst), .bit_clk_i(bit_clk),
        .mode_i(mode), .tx_en_i(tx_en), .txd_i(txd), .line_rx_act_i(rx_act),
        .line_rx_code_i(rx_code), .line_rxd_i(rxd), .line_tx_o(line_tx), .mii_rx_o(mii_rx),
        .tx_clk_o(), .rx_clk_o(), .link_crs_mclk_o(crs_m));
    mac_model mac (.bit_clk_i(bit_clk), .mode_i(mode), .tx_en_o(tx_en), .txd_o(txd));
    ////////////////////////////////////////////////////////////////////////
    function automatic int fit(input int v, input int lo, input int hi);
        return (v >= lo && v <= hi) ? v : lo;
    endfunction
    function automatic logic pick(input int w);
        case (w)
            0: return line_tx.tx_active;
            1: return line_tx.tx_eop_high;
            2: return mii_rx.crs;
            default: return mii_rx.rx_dv;
        endcase
    endfunction
    // counts bit clock rises; the bound keeps a dead output from hanging
    task automatic lat(input int w, input logic lvl, output int n);
        n = 0;
        while (pick(w) !== lvl && n < 60) begin
            @(posedge bit_clk);
            #1;
            n++;
        end
    endtask
    task automatic set_mode(input mode_t m);
        @(negedge bit_clk);
        mode = m;
        repeat (4) @(negedge bit_clk);
    endtask
    task automatic tx_run(input mode_t m, input int lo, input int hi);
        int n;
        set_mode(m);
        fork
            mac.send(10);
            begin
                @(posedge tx_en);
                lat(0, 1'b1, n);
                `CHK("tx start", fit(n, lo, hi), n)
                @(negedge tx_en);
                lat(0, 1'b0, n);
                if (!m[1]) `CHK("tx end", fit(n, TX_ESD_BITS - 1, TX_ESD_BITS + 2), n)
                lat(1, 1'b0, n);
                if (m[1]) `CHK("eop high", fit(n, EOP_HIGH_CYC - 1, EOP_HIGH_CYC + 1), n)
            end
        join
        repeat (20) @(negedge bit_clk);
        $display("tx test done, mode %0d", m);
    endtask
    task automatic rx_run(input mode_t m, input int lo, input int hi, input int dv, input int off);
        int n;
        int d;
        set_mode(m);
        rx_act = 1'b1;
        rx_code = 1'b1;
        rxd = 4'hB;
        lat(2, 1'b1, n);
        `CHK("crs on", fit(n, lo, hi), n)
        lat(3, 1'b1, d);
        `CHK("rx_dv on", fit(n + d, dv - 1, dv + 2), n + d)
        `CHK("rxd", (m == MODE_10SER) ? 4'h1 : 4'hB, mii_rx.rxd)
        repeat (30) @(negedge bit_clk);
        `CHK("crs in mclk", 1'b1, crs_m)
        rx_act = 1'b0;
        rx_code = 1'b0;
        rxd = 4'h5;
        lat(2, 1'b0, n);
        if (off > 0) `CHK("crs off", fit(n, off - 1, off + 2), n)
        repeat (40) @(negedge bit_clk);
        $display("rx test done, mode %0d", m);
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        tx_run(MODE_100TX, TX_SSD_BITS - 1, TX_SSD_BITS + 2);
        tx_run(MODE_100FX, TX_SSD_BITS - 1, TX_SSD_BITS + 2);
        tx_run(MODE_10MII, 2, 5);
        tx_run(MODE_10SER, 2, 5);
        rx_run(MODE_100TX, CRS_ON_TX_BITS - 1, CRS_ON_TX_BITS + 2, RXD_TX_BITS, CRS_OFF_TX_BITS);
        rx_run(MODE_100FX, CRS_ON_FX_BITS - 1, CRS_ON_FX_BITS + 2, RXD_FX_BITS, CRS_OFF_FX_BITS);
        rx_run(MODE_10SER, 1, CRS10_MAX_NS / BIT10_NS, RXDV10_BITS, 0);
        end_of_test();
    end
endmodule
bind phy_mii_datapath_latency lat_monitor mon (.sys_rst_i, .bit_clk_i, .mode_i, .tx_en_i,
    .line_rx_act_i, .line_rx_code_i, .line_tx_o, .mii_rx_o);
